// ### pin_mux_pkg.sv
package pin_mux_pkg;
  localparam logic [15:0] port1_sel_index = 16'hf820;
  localparam logic [15:0] port2_sel_index = 16'hf822;
  localparam logic [15:0] port3_sel_index = 16'hf824;
  localparam logic [7:0]  sel_reset       = 8'h00;
  localparam int          addr_w          = 16;
  localparam int          index_lsb       = 2;

  typedef struct packed {
    logic [7:0] port1_function_select;
    logic [7:0] port2_function_select;
    logic [7:0] port3_function_select;
    logic [31:0] prdata;
  } mux_state_t;

  typedef struct packed {
    logic bus_grant_ack_out;
    logic bus_lock_n;
    logic serial0_terminal_ready_n;
    logic serial0_req_send_n;
    logic serial0_tx_line;
    logic [4:0] chip_select_n;
    logic serial_comm_clock;
    logic power_down_indicator;
  } periph_out_t;

  typedef struct packed {
    logic bus_request;
    logic serial0_ring_in_n;
    logic serial0_set_ready_n;
    logic serial0_carrier_n;
    logic serial0_clear_send_n;
    logic serial0_rx_line;
    logic master_request7;
    logic master_request6;
    logic master_request5;
    logic master_request1;
  } periph_in_t;
endpackage

// ### pin_bit_mux.sv
`timescale 1ns/1ps
module pin_bit_mux (
  input  wire logic sel,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  input  wire logic periph_out,
  input  wire logic periph_oe,
  input  wire logic pin_in,
  input  wire logic idle_level,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      periph_in
);
  assign pad_out   = sel ? periph_out : gpio_out;
  assign pad_oe    = sel ? periph_oe : gpio_oe;
  assign periph_in = sel ? pin_in : idle_level;
endmodule

// ### port_pin_function_select.sv
`timescale 1ns/1ps
module port_pin_function_select #(
  parameter int NPINS = 8
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [3*NPINS-1:0]         gpio_out,
  input  wire logic [3*NPINS-1:0]         gpio_oe,
  input  wire logic [1:0]                 alt_mux_out,
  input  wire logic [1:0]                 alt_mux_oe,
  input  wire pin_mux_pkg::periph_out_t   periph_out,
  output pin_mux_pkg::periph_in_t         periph_in,
  input  wire logic [3*NPINS-1:0]         pad_in,
  output logic      [3*NPINS-1:0]         pad_out,
  output logic      [3*NPINS-1:0]         pad_oe,
  output logic      [7:0]                 port3_alt_sel
);
  // ==========================================================
  // Register state
  pin_mux_pkg::mux_state_t state_reg;
  pin_mux_pkg::mux_state_t state_next;

  logic [pin_mux_pkg::addr_w-1:0] word_addr;
  logic                           spare_zero;
  logic                           hit1;
  logic                           hit2;
  logic                           hit3;
  logic                           access;

  assign word_addr  = paddr[pin_mux_pkg::index_lsb +: pin_mux_pkg::addr_w];
  assign spare_zero = (paddr[31:pin_mux_pkg::index_lsb+pin_mux_pkg::addr_w] == '0)
                   && (paddr[pin_mux_pkg::index_lsb-1:0] == '0);
  assign hit1       = spare_zero && (word_addr == pin_mux_pkg::port1_sel_index);
  assign hit2       = spare_zero && (word_addr == pin_mux_pkg::port2_sel_index);
  assign hit3       = spare_zero && (word_addr == pin_mux_pkg::port3_sel_index);
  assign access    = psel && penable;

  // ==========================================================
  // APB slave, zero wait states
  always_comb begin
    state_next = state_reg;
    if (access && pwrite && pstrb[0]) begin
      if (hit1) begin
        state_next.port1_function_select = pwdata[7:0];
      end
      if (hit2) begin
        state_next.port2_function_select = pwdata[7:0];
      end
      if (hit3) begin
        state_next.port3_function_select = pwdata[7:0];
      end
    end
    if (psel && !penable && !pwrite) begin
      if (hit1) begin
        state_next.prdata = {24'h000000, state_reg.port1_function_select};
      end else if (hit2) begin
        state_next.prdata = {24'h000000, state_reg.port2_function_select};
      end else if (hit3) begin
        state_next.prdata = {24'h000000, state_reg.port3_function_select};
      end else begin
        state_next.prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.port1_function_select <= pin_mux_pkg::sel_reset;
      state_reg.port2_function_select <= pin_mux_pkg::sel_reset;
      state_reg.port3_function_select <= pin_mux_pkg::sel_reset;
      state_reg.prdata                <= 32'h00000000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata        = state_reg.prdata;
  assign pready        = 1'b1;
  assign pslverr       = access && !(hit1 || hit2 || hit3);
  assign port3_alt_sel = state_reg.port3_function_select;

  // ==========================================================
  // Per-pin peripheral wiring
  logic [3*NPINS-1:0] sel_all;
  logic [3*NPINS-1:0] p_out;
  logic [3*NPINS-1:0] p_oe;
  logic [3*NPINS-1:0] p_in;
  logic [3*NPINS-1:0] idle;

  assign sel_all = {state_reg.port3_function_select,
                    state_reg.port2_function_select,
                    state_reg.port1_function_select};

  always_comb begin
    p_out = '0;
    p_oe  = '0;
    idle  = '0;
    // Port 1
    p_out[7] = periph_out.bus_grant_ack_out;
    p_oe[7]  = 1'b1;
    idle[6]  = 1'b0;
    p_out[5] = periph_out.bus_lock_n;
    p_oe[5]  = 1'b1;
    idle[4]  = 1'b1;
    idle[3]  = 1'b1;
    p_out[2] = periph_out.serial0_terminal_ready_n;
    p_oe[2]  = 1'b1;
    p_out[1] = periph_out.serial0_req_send_n;
    p_oe[1]  = 1'b1;
    idle[0]  = 1'b1;
    // Port 2
    idle[15]  = 1'b1;
    p_out[14] = periph_out.serial0_tx_line;
    p_oe[14]  = 1'b1;
    idle[13]  = 1'b1;
    p_out[12:8] = periph_out.chip_select_n;
    p_oe[12:8]  = 5'h1f;
    // Port 3
    p_out[23] = periph_out.serial_comm_clock;
    p_oe[23]  = 1'b1;
    p_out[22] = periph_out.power_down_indicator;
    p_oe[22]  = 1'b1;
    idle[21:18] = 4'h0;
    p_out[17:16] = alt_mux_out;
    p_oe[17:16]  = alt_mux_oe;
  end

  genvar g;
  generate
    for (g = 0; g < 3*NPINS; g++) begin : g_pin
      pin_bit_mux u_mux (
        .sel        (sel_all[g]),
        .gpio_out   (gpio_out[g]),
        .gpio_oe    (gpio_oe[g]),
        .periph_out (p_out[g]),
        .periph_oe  (p_oe[g]),
        .pin_in     (pad_in[g]),
        .idle_level (idle[g]),
        .pad_out    (pad_out[g]),
        .pad_oe     (pad_oe[g]),
        .periph_in  (p_in[g])
      );
    end
  endgenerate

  always_comb begin
    periph_in.bus_request         = p_in[6];
    periph_in.serial0_ring_in_n   = p_in[4];
    periph_in.serial0_set_ready_n = p_in[3];
    periph_in.serial0_carrier_n   = p_in[0];
    periph_in.serial0_clear_send_n = p_in[15];
    periph_in.serial0_rx_line     = p_in[13];
    periph_in.master_request7     = p_in[21];
    periph_in.master_request6     = p_in[20];
    periph_in.master_request5     = p_in[19];
    periph_in.master_request1     = p_in[18];
  end
endmodule

// ### port_pin_function_select_chk.sv
`timescale 1ns/1ps
// ==========
// Checker
module port_pin_function_select_chk #(
  parameter int NPINS = 8
) (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic [31:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic [3:0]               pstrb,
  input wire logic [1:0]               alt_mux_out,
  input wire logic [7:0]               port3_alt_sel,
  input wire logic [3*NPINS-1:0]       gpio_out,
  input wire logic [3*NPINS-1:0]       pad_in,
  input wire logic [3*NPINS-1:0]       pad_out,
  input wire pin_mux_pkg::periph_out_t periph_out,
  input wire pin_mux_pkg::periph_in_t  periph_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam logic [31:0] adr1 = {14'h0000, pin_mux_pkg::port1_sel_index, 2'h0};
  localparam logic [31:0] adr2 = {14'h0000, pin_mux_pkg::port2_sel_index, 2'h0};
  localparam logic [31:0] adr3 = {14'h0000, pin_mux_pkg::port3_sel_index, 2'h0};
  logic hit;
  logic wr3;
  assign hit = paddr inside {adr1, adr2, adr3};
  assign wr3 = psel && penable && pwrite && pstrb[0] && paddr == adr3;
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_wr3;
    psel && !penable ##1 wr3;
  endsequence
  chk_ready_high: assert property (psel |-> pready) else $error("pready low");
  chk_bad_addr: assert property (s_acc ##0 !hit |-> pslverr) else $error("no error");
  chk_good_addr: assert property (s_acc ##0 hit |-> !pslverr) else $error("error");
  chk_bad_read: assert property (s_acc ##0 !hit && !pwrite |-> prdata == 32'h0)
    else $error("unmapped data");
  chk_sel_write: assert property (s_wr3 |=> port3_alt_sel == $past(pwdata[7:0]))
    else $error("select not written");
  chk_sel_hold: assert property (!wr3 |=> $stable(port3_alt_sel)) else $error("select moved");
  chk_clock_pin: assert property (pad_out[23] == (port3_alt_sel[7] ?
    periph_out.serial_comm_clock : gpio_out[23])) else $error("pin 23");
  chk_power_pin: assert property (pad_out[22] == (port3_alt_sel[6] ?
    periph_out.power_down_indicator : gpio_out[22])) else $error("pin 22");
  chk_irq_high: assert property (periph_in.master_request7 == (port3_alt_sel[5] && pad_in[21]))
    else $error("request7");
  chk_irq_low: assert property (periph_in.master_request1 == (port3_alt_sel[2] && pad_in[18]))
    else $error("request1");
  chk_alt_pin: assert property (pad_out[16] == (port3_alt_sel[0] ? alt_mux_out[0] : gpio_out[16]))
    else $error("pin 16");
endmodule
bind port_pin_function_select port_pin_function_select_chk #(.NPINS(NPINS)) i_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .pstrb, .alt_mux_out,
  .port3_alt_sel, .gpio_out, .pad_in, .pad_out, .periph_out, .periph_in);

// ### port_pin_function_select_test.sv
`timescale 1ns/1ps
// ==========
// Bench
module port_pin_function_select_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic        err;
  logic [3:0]  pstrb = 4'hf;
  logic [23:0] gpio_out = 0, gpio_oe = 24'h5a3c96, pad_in = 0, pad_out, pad_oe;
  logic [1:0]  alt_mux_out = 0, alt_mux_oe = 2'h3;
  logic [7:0]  port3_alt_sel;
  pin_mux_pkg::periph_out_t periph_out = '0;
  pin_mux_pkg::periph_in_t  periph_in;
  int          fails = 0, num_checks = 0, cyc = 0;
  logic [31:0] adr [3] = '{{14'h0000, pin_mux_pkg::port1_sel_index, 2'h0},
                           {14'h0000, pin_mux_pkg::port2_sel_index, 2'h0},
                           {14'h0000, pin_mux_pkg::port3_sel_index, 2'h0}};
  logic [7:0]  val [3] = '{8'ha5, 8'h5a, 8'hc3};
  int          opin [12] = '{22, 23, 8, 9, 10, 11, 12, 14, 1, 2, 5, 7};
  int          ipin [10] = '{18, 19, 20, 21, 13, 15, 0, 3, 4, 6};
  port_pin_function_select i_port_pin_function_select (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .gpio_out, .gpio_oe, .alt_mux_out,
    .alt_mux_oe, .periph_out, .periph_in, .pad_in, .pad_out, .pad_oe, .port3_alt_sel);
  always #5 pclk = ~pclk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails = fails + 1;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (adr[i]) begin
      xfer(0, adr[i], 0);
      chk("reset", rd, 0);
      xfer(1, adr[i], 32'hffffff00 | val[i]);
    end
    pstrb <= 4'he;
    xfer(1, adr[0], 0);
    pstrb <= 4'hf;
    xfer(1, 32'h0003e098, 32'hff);
    chk("unmapped error", 32'(err), 1);
    xfer(0, 32'h0003e098, 0);
    chk("unmapped", rd, 0);
    xfer(0, 32'h0003e082, 0);
    chk("misaligned error", 32'(err), 1);
    foreach (adr[i]) begin
      xfer(0, adr[i], 0);
      chk("readback", rd, 32'(val[i]));
      chk("mapped error", 32'(err), 0);
      xfer(1, adr[i], 32'hff);
    end
    for (int k = 0; k < 12; k++) begin
      periph_out <= 12'(1) << k;
      pad_in <= (k < 10) ? 24'(1) << ipin[k] : 24'h0;
      @(posedge pclk);
      chk("out pin", 32'(pad_out & 24'hc35fa6), 32'(24'(1) << opin[k]));
      if (k < 10) chk("in pin", 32'(periph_in), 32'(10'(1) << k));
    end
    alt_mux_out <= 2'h2;
    alt_mux_oe <= 2'h1;
    @(posedge pclk);
    chk("alt pins", 32'(pad_out[17:16]), 32'h2);
    chk("periph enables", 32'(pad_oe), 32'hc15fa6);
    chk("port3 select", 32'(port3_alt_sel), 32'hff);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk("reset pins", 32'(pad_out), 32'h0);
    presetn <= 1;
    @(posedge pclk);
    foreach (adr[i]) begin
      xfer(0, adr[i], 0);
      chk("reset again", rd, 0);
    end
    foreach (adr[i]) xfer(1, adr[i], 0);
    gpio_out <= 24'h6b29d4;
    periph_out <= '1;
    pad_in <= 24'hffffff;
    @(posedge pclk);
    chk("gpio pins", 32'(pad_out), 32'h6b29d4);
    chk("gpio enables", 32'(pad_oe), 32'h5a3c96);
    chk("idle inputs", 32'(periph_in), 32'h1f0);
    pad_in <= 24'h000000;
    @(posedge pclk);
    chk("idle low", 32'(periph_in), 32'h1f0);
    test_done();
  end
endmodule
